// file: bench/bridge_window_and_control_regs_test.sv
// Self-checking bench for the bridge window, interrupt and control registers
`timescale 1ns/1ps
module bridge_window_and_control_regs_test;
  import bridge_regs_pkg::*;
  logic clk, rst_b, mem_req, io_req, poison, pin_ld, psel, penable, pwrite;
  logic pready, pslverr, mem_fwd, io_dn, io_up, poison_rpt, irq;
  logic [63:0] mem_addr;
  logic [31:0] io_addr, pwdata, prdata, obs;
  logic [7:0] paddr, pin_val;
  logic [3:0] pstrb;
  logic [2:0] err_msg, err_fwd;
  logic [1:0] port_rst_b;
  logic mem_fwd2;
  logic [1:0] port_rst_b2;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  assign obs = {22'h0, irq, port_rst_b, poison_rpt, err_fwd, io_up, io_dn, mem_fwd};
  cfg_requester rc (.clk_in(clk), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb),
    .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));
  bridge_window_and_control_regs dut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .MEM_REQ_IN(mem_req), .MEM_ADDR_IN(mem_addr), .IO_REQ_IN(io_req), .IO_ADDR_IN(io_addr),
    .ERR_MSG_IN(err_msg), .POISON_IN(poison), .IRQ_PIN_LOAD_IN(pin_ld),
    .IRQ_PIN_VALUE_IN(pin_val), .MEM_FWD_OUT(mem_fwd), .IO_FWD_DOWN_OUT(io_dn),
    .IO_FWD_UP_OUT(io_up), .ERR_FWD_OUT(err_fwd), .POISON_REPORT_OUT(poison_rpt),
    .PORT_RST_B_OUT(port_rst_b), .IRQ_OUT(irq));
  // Upstream copy on port two, sharing the bus and the decode inputs
  bridge_window_and_control_regs #(.IS_UPSTREAM(1'b1), .PORT_INDEX(2)) dut_up (
    .CLOCK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
    .PRDATA_OUT(), .PREADY_OUT(), .PSLVERR_OUT(), .MEM_REQ_IN(mem_req),
    .MEM_ADDR_IN(mem_addr), .IO_REQ_IN(io_req), .IO_ADDR_IN(io_addr), .ERR_MSG_IN(err_msg),
    .POISON_IN(poison), .IRQ_PIN_LOAD_IN(pin_ld), .IRQ_PIN_VALUE_IN(pin_val),
    .MEM_FWD_OUT(mem_fwd2), .IO_FWD_DOWN_OUT(), .IO_FWD_UP_OUT(), .ERR_FWD_OUT(),
    .POISON_REPORT_OUT(), .PORT_RST_B_OUT(port_rst_b2), .IRQ_OUT());
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e, ok;
    rc.xfer(1'b1, a, d, r, e, ok);
    chk({31'h0, ok}, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
    logic [31:0] r;
    logic e, ok;
    rc.xfer(1'b0, a, 32'h0, r, e, ok);
    chk(r, exp);
    chk({30'h0, ok, e}, {30'h0, 1'b1, exp_e});
  endtask
  // Kind 1 memory, 2 I/O, 3 error bits a[2:0] with poison a[3]; outputs one cycle later
  task automatic dec(input logic [1:0] k, input logic [63:0] a, input logic [31:0] exp);
    @(posedge clk);
    mem_req <= (k == 2'h1);
    io_req <= (k == 2'h2);
    mem_addr <= a;
    io_addr <= a[31:0];
    err_msg <= (k == 2'h3) ? a[2:0] : 3'h0;
    poison <= (k == 2'h3) & a[3];
    @(posedge clk);
    mem_req <= 1'b0;
    io_req <= 1'b0;
    err_msg <= 3'h0;
    poison <= 1'b0;
    #1;
    chk(obs, exp);
  endtask
  initial begin
    {rst_b, mem_req, io_req, poison, pin_ld} = 5'h0;
    mem_addr = 64'h0;
    io_addr = 32'h0;
    err_msg = 3'h0;
    pin_val = 8'h00;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h2C, 32'h0, 1'b0);
    rd(8'h30, 32'h0, 1'b0);
    rd(8'h34, 32'h80, 1'b0);
    rd(8'h3C, 32'h0, 1'b0);
    rd(8'h28, 32'h0, 1'b0);
    $display("test reset_values done");
    wr(8'h2C, 32'hA5A55A5A);
    rd(8'h2C, 32'hA5A55A5A, 1'b0);
    wr(8'h30, 32'hBEEF1234);
    rd(8'h30, 32'hBEEF1234, 1'b0);
    wr(8'h28, 32'h12345678);
    rd(8'h28, 32'h12345678, 1'b0);
    wr(8'h34, 32'hFFFFFFFF);
    rd(8'h34, 32'h80, 1'b0);
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h005F00FF, 1'b0);
    dec(2'h0, 64'h0, 32'h100);
    chk({30'h0, port_rst_b2}, 32'h0);
    wr(8'h3C, 32'h0);
    dec(2'h0, 64'h0, 32'h180);
    rd(8'h80, 32'h0, 1'b1);
    rd(8'h2D, 32'h0, 1'b1);
    $display("test register_access done");
    wr(8'h28, 32'h1);
    wr(8'h2C, 32'h1);
    wr(8'h24, 32'hFFF00000);
    dec(2'h1, 64'h1FFFFFFFF, 32'h181);
    dec(2'h1, 64'h100000000, 32'h181);
    dec(2'h1, 64'h200000000, 32'h180);
    dec(2'h1, 64'h0FFFFFFFF, 32'h180);
    dec(2'h1, 64'h0000A0000, 32'h180);
    $display("test prefetch_window done");
    wr(8'h1C, 32'h0000F000);
    wr(8'h30, 32'h0);
    dec(2'h2, 64'h0100, 32'h182);
    dec(2'h2, 64'h10000, 32'h180);
    wr(8'h3C, 32'h00040000);
    dec(2'h2, 64'h0100, 32'h184);
    dec(2'h2, 64'h03FF, 32'h184);
    dec(2'h2, 64'h0500, 32'h184);
    dec(2'h2, 64'h0400, 32'h182);
    $display("test io_window done");
    wr(8'h30, 32'h1);
    wr(8'h3C, 32'h00080000);
    dec(2'h1, 64'hA0000, 32'h181);
    chk({31'h0, mem_fwd2}, 32'h0);
    dec(2'h1, 64'hBFFFF, 32'h181);
    dec(2'h1, 64'hC0000, 32'h180);
    dec(2'h1, 64'h9FFFF, 32'h180);
    dec(2'h2, 64'h3B0, 32'h182);
    dec(2'h2, 64'h3BB, 32'h182);
    dec(2'h2, 64'h3BC, 32'h180);
    dec(2'h2, 64'h3DF, 32'h182);
    dec(2'h2, 64'h3E0, 32'h180);
    dec(2'h2, 64'h13C0, 32'h182);
    wr(8'h3C, 32'h00180000);
    dec(2'h2, 64'h13C0, 32'h180);
    dec(2'h2, 64'h3C0, 32'h182);
    $display("test vga_decode done");
    wr(8'h3C, 32'h0);
    dec(2'h3, 64'h7, 32'h180);
    dec(2'h3, 64'h8, 32'h180);
    wr(8'h3C, 32'h00030000);
    dec(2'h3, 64'h5, 32'h1A8);
    dec(2'h3, 64'h8, 32'h1C0);
    rd(8'h40, 32'h7, 1'b0);
    wr(8'h44, 32'h1);
    dec(2'h0, 64'h0, 32'h380);
    wr(8'h40, 32'h1);
    dec(2'h0, 64'h0, 32'h180);
    rd(8'h40, 32'h6, 1'b0);
    wr(8'h44, 32'h7);
    dec(2'h0, 64'h0, 32'h380);
    wr(8'h40, 32'h7);
    dec(2'h0, 64'h0, 32'h180);
    rd(8'h40, 32'h0, 1'b0);
    $display("test events_and_interrupt done");
    @(posedge clk);
    pin_ld <= 1'b1;
    pin_val <= 8'h01;
    @(posedge clk);
    pin_ld <= 1'b0;
    rd(8'h3C, 32'h00030100, 1'b0);
    $display("test irq_pin_load done");
    tally_and_finish();
  end
endmodule

// file: bench/cfg_requester.sv
// APB requester that stands in for the host issuing configuration accesses
`timescale 1ns/1ps
module cfg_requester (
  input wire logic clk_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out,
  output logic [3:0] pstrb_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  initial begin
    {psel_out, penable_out, pwrite_out} = 3'h0;
    paddr_out = 8'h00;
    pwdata_out = 32'h00000000;
    pstrb_out = 4'h0;
  end
  // One transfer: setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output logic ok);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    pstrb_out <= 4'hF;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1);
    r = prdata_in;
    e = pslverr_in;
    // Answer expected with no wait state
    ok = (n == 1);
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // Released lines carry no stale value
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask
endmodule

// file: hdl/bridge_regs_pkg.sv
// Constants, types and field layout for the bridge window and control registers
package bridge_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_IO_LOW = 8'h1C;
  localparam logic [7:0] OFS_PF_LOW = 8'h24;
  localparam logic [7:0] OFS_PF_BASE_HI = 8'h28;
  localparam logic [7:0] OFS_PF_LIM_HI = 8'h2C;
  localparam logic [7:0] OFS_IO_HI = 8'h30;
  localparam logic [7:0] OFS_CAP = 8'h34;
  localparam logic [7:0] OFS_BRCTL = 8'h3C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
  localparam logic [7:0] CAP_PTR_VAL = 8'h80;
  localparam logic [7:0] IRQ_PIN_RST = 8'h00;
  localparam logic [3:0] ADDR_CAP_CODE = 4'h1;
  localparam logic [19:0] MEM_LOW_ONES = 20'hFFFFF;
  localparam logic [11:0] IO_LOW_ONES = 12'hFFF;
  localparam logic [31:0] VGA_MEM_LO = 32'h000A0000;
  localparam logic [31:0] VGA_MEM_HI = 32'h000BFFFF;
  localparam logic [9:0] VGA_IO_A_LO = 10'h3B0;
  localparam logic [9:0] VGA_IO_A_HI = 10'h3BB;
  localparam logic [9:0] VGA_IO_B_LO = 10'h3C0;
  localparam logic [9:0] VGA_IO_B_HI = 10'h3DF;
  localparam int VGA_RESERVED_PORT = 2;
  localparam int NUM_DS_PORTS = 2;
  localparam int BIT_PARITY = 16;
  localparam int BIT_SERR = 17;
  localparam int BIT_ISA = 18;
  localparam int BIT_VGA = 19;
  localparam int BIT_VGA16 = 20;
  localparam int BIT_SBR = 22;
  localparam int EV_POISON = 0;
  localparam int EV_ERR_FWD = 1;
  localparam int EV_ERR_BLK = 2;
  localparam int NUM_EV = 3;

  typedef struct packed {
    logic parity_resp;
    logic secondary_error_forward_enable;
    logic legacy_io_alias_mode;
    logic vga_en;
    logic vga_16bit;
    logic sec_bus_reset;
  } bridge_ctl_t;

  typedef struct packed {
    logic [31:0] pf_base_hi;
    logic [31:0] pf_lim_hi;
    logic [11:0] pf_base_lo;
    logic [11:0] pf_lim_lo;
    logic [3:0] io_base_lo;
    logic [3:0] io_lim_lo;
    logic [15:0] io_base_hi;
    logic [15:0] io_lim_hi;
    logic [7:0] irq_line;
    logic [7:0] irq_pin;
    bridge_ctl_t ctl;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic mem_fwd;
    logic io_down;
    logic io_up;
    logic [2:0] err_fwd;
    logic poison_rpt;
    logic [NUM_DS_PORTS-1:0] port_rst_b;
  } state_t;
endpackage

// file: hdl/bridge_window_and_control_regs.sv
// Bridge window, interrupt and control registers with forwarding decode
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module bridge_window_and_control_regs
  import bridge_regs_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b0,
  parameter int PORT_INDEX = 1
) (
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [DATA_W-1:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [DATA_W-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic MEM_REQ_IN,
  input wire logic [63:0] MEM_ADDR_IN,
  input wire logic IO_REQ_IN,
  input wire logic [31:0] IO_ADDR_IN,
  input wire logic [2:0] ERR_MSG_IN,
  input wire logic POISON_IN,
  input wire logic IRQ_PIN_LOAD_IN,
  input wire logic [7:0] IRQ_PIN_VALUE_IN,
  output logic MEM_FWD_OUT,
  output logic IO_FWD_DOWN_OUT,
  output logic IO_FWD_UP_OUT,
  output logic [2:0] ERR_FWD_OUT,
  output logic POISON_REPORT_OUT,
  output logic [NUM_DS_PORTS-1:0] PORT_RST_B_OUT,
  output logic IRQ_OUT
);

  localparam bit VGA_OK = (PORT_INDEX != VGA_RESERVED_PORT);

  state_t s_q;
  state_t s_d;
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic [31:0] rdata;
  logic [31:0] wmask;
  logic [63:0] pf_base;
  logic [63:0] pf_limit;
  logic [31:0] io_base;
  logic [31:0] io_limit;
  logic pf_hit;
  logic io_hit;
  logic vga_mem_hit;
  logic vga_io_hit;
  logic isa_alias;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] clr;
  logic [31:0] old_w;
  logic [31:0] new_w;

  // Window bounds with implied low bits
  assign pf_base = {s_q.pf_base_hi, s_q.pf_base_lo, 20'h00000};
  assign pf_limit = {s_q.pf_lim_hi, s_q.pf_lim_lo, MEM_LOW_ONES};
  assign io_base = {s_q.io_base_hi, s_q.io_base_lo, 12'h000};
  assign io_limit = {s_q.io_lim_hi, s_q.io_lim_lo, IO_LOW_ONES};

  window_compare #(.W(64)) u_pf_cmp (
    .addr_in(MEM_ADDR_IN),
    .base_in(pf_base),
    .limit_in(pf_limit),
    .hit_out(pf_hit)
  );

  window_compare #(.W(32)) u_io_cmp (
    .addr_in(IO_ADDR_IN),
    .base_in(io_base),
    .limit_in(io_limit),
    .hit_out(io_hit)
  );

  // VGA decode
  always_comb begin
    vga_mem_hit = (MEM_ADDR_IN[63:32] == 32'h00000000) &&
                  (MEM_ADDR_IN[31:0] >= VGA_MEM_LO) &&
                  (MEM_ADDR_IN[31:0] <= VGA_MEM_HI);
    vga_io_hit = ((IO_ADDR_IN[9:0] >= VGA_IO_A_LO) && (IO_ADDR_IN[9:0] <= VGA_IO_A_HI)) ||
                 ((IO_ADDR_IN[9:0] >= VGA_IO_B_LO) && (IO_ADDR_IN[9:0] <= VGA_IO_B_HI));
    if (s_q.ctl.vga_16bit) begin
      vga_io_hit = vga_io_hit && (IO_ADDR_IN[31:10] == 22'h000000);
    end
    vga_mem_hit = vga_mem_hit && s_q.ctl.vga_en;
    vga_io_hit = vga_io_hit && s_q.ctl.vga_en;
    isa_alias = s_q.ctl.legacy_io_alias_mode && io_hit &&
                (IO_ADDR_IN[31:16] == 16'h0000) && (IO_ADDR_IN[9:8] != 2'h0);
  end

  // Byte lane mask from APB strobes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{PSTRB_IN[i]}};
    end
  end

  // Read mux and address decode
  always_comb begin
    rdata = 32'h00000000;
    mapped = (PADDR_IN[1:0] == 2'h0);
    case (PADDR_IN)
      OFS_IO_LOW: rdata = {16'h0000, s_q.io_lim_lo, ADDR_CAP_CODE, s_q.io_base_lo, ADDR_CAP_CODE};
      OFS_PF_LOW: rdata = {s_q.pf_lim_lo, ADDR_CAP_CODE, s_q.pf_base_lo, ADDR_CAP_CODE};
      OFS_PF_BASE_HI: rdata = s_q.pf_base_hi;
      OFS_PF_LIM_HI: rdata = s_q.pf_lim_hi;
      OFS_IO_HI: rdata = {s_q.io_lim_hi, s_q.io_base_hi};
      OFS_CAP: rdata = {24'h000000, CAP_PTR_VAL};
      OFS_BRCTL: begin
        rdata[7:0] = s_q.irq_line;
        rdata[15:8] = s_q.irq_pin;
        rdata[BIT_PARITY] = s_q.ctl.parity_resp;
        rdata[BIT_SERR] = s_q.ctl.secondary_error_forward_enable;
        rdata[BIT_ISA] = s_q.ctl.legacy_io_alias_mode;
        rdata[BIT_VGA] = s_q.ctl.vga_en;
        rdata[BIT_VGA16] = s_q.ctl.vga_16bit;
        rdata[BIT_SBR] = s_q.ctl.sec_bus_reset;
      end
      OFS_IRQ_STAT: rdata[NUM_EV-1:0] = s_q.status;
      OFS_IRQ_MASK: rdata[NUM_EV-1:0] = s_q.mask;
      default: mapped = 1'b0;
    endcase
    old_w = rdata;
    new_w = (old_w & ~wmask) | (PWDATA_IN & wmask);
  end

  assign setup = PSEL_IN && !PENABLE_IN;
  assign access = PSEL_IN && PENABLE_IN && s_q.pready;
  assign wr = access && PWRITE_IN && mapped;

  // Events seen on the secondary side
  always_comb begin
    ev = '0;
    ev[EV_POISON] = POISON_IN && s_q.ctl.parity_resp;
    ev[EV_ERR_FWD] = (ERR_MSG_IN != 3'h0) && s_q.ctl.secondary_error_forward_enable;
    ev[EV_ERR_BLK] = (ERR_MSG_IN != 3'h0) && !s_q.ctl.secondary_error_forward_enable;
    clr = '0;
    if (wr && (PADDR_IN == OFS_IRQ_STAT)) begin
      clr = wmask[NUM_EV-1:0] & PWDATA_IN[NUM_EV-1:0];
    end
  end

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.pready = setup;
    s_d.pslverr = setup && !mapped;
    s_d.prdata = (setup && !PWRITE_IN) ? rdata : 32'h00000000;
    if (wr) begin
      case (PADDR_IN)
        OFS_IO_LOW: begin
          s_d.io_base_lo = new_w[7:4];
          s_d.io_lim_lo = new_w[15:12];
        end
        OFS_PF_LOW: begin
          s_d.pf_base_lo = new_w[15:4];
          s_d.pf_lim_lo = new_w[31:20];
        end
        OFS_PF_BASE_HI: s_d.pf_base_hi = new_w;
        OFS_PF_LIM_HI: s_d.pf_lim_hi = new_w;
        OFS_IO_HI: begin
          s_d.io_base_hi = new_w[15:0];
          s_d.io_lim_hi = new_w[31:16];
        end
        OFS_BRCTL: begin
          s_d.irq_line = new_w[7:0];
          s_d.ctl.parity_resp = new_w[BIT_PARITY];
          s_d.ctl.secondary_error_forward_enable = new_w[BIT_SERR];
          s_d.ctl.legacy_io_alias_mode = new_w[BIT_ISA];
          s_d.ctl.vga_en = new_w[BIT_VGA] && VGA_OK;
          s_d.ctl.vga_16bit = new_w[BIT_VGA16] && VGA_OK;
          s_d.ctl.sec_bus_reset = new_w[BIT_SBR];
        end
        OFS_IRQ_MASK: s_d.mask = new_w[NUM_EV-1:0];
        default: s_d.mask = s_q.mask;
      endcase
    end
    if (IRQ_PIN_LOAD_IN && !IS_UPSTREAM) begin
      s_d.irq_pin = IRQ_PIN_VALUE_IN;
    end
    s_d.status = (s_q.status & ~clr) | ev;
    s_d.irq = |(s_q.status & s_q.mask);
    s_d.mem_fwd = MEM_REQ_IN && (pf_hit || vga_mem_hit);
    s_d.io_up = IO_REQ_IN && isa_alias;
    s_d.io_down = IO_REQ_IN && ((io_hit && !isa_alias) || vga_io_hit);
    s_d.err_fwd = s_q.ctl.secondary_error_forward_enable ? ERR_MSG_IN : 3'h0;
    s_d.poison_rpt = ev[EV_POISON];
    for (int p = 0; p < NUM_DS_PORTS; p++) begin
      s_d.port_rst_b[p] = !(s_q.ctl.sec_bus_reset && (IS_UPSTREAM || p == 0));
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s_q <= '0;
      s_q.irq_pin <= IRQ_PIN_RST;
      s_q.port_rst_b <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA_OUT = s_q.prdata;
  assign PREADY_OUT = s_q.pready;
  assign PSLVERR_OUT = s_q.pslverr;
  assign MEM_FWD_OUT = s_q.mem_fwd;
  assign IO_FWD_DOWN_OUT = s_q.io_down;
  assign IO_FWD_UP_OUT = s_q.io_up;
  assign ERR_FWD_OUT = s_q.err_fwd;
  assign POISON_REPORT_OUT = s_q.poison_rpt;
  assign PORT_RST_B_OUT = s_q.port_rst_b;
  assign IRQ_OUT = s_q.irq;

  // Checks
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_read_setup(logic [7:0] ofs);
    PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == ofs;
  endsequence

  sequence s_full_write(logic [7:0] ofs);
    PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == ofs && PSTRB_IN == 4'hF;
  endsequence

  property p_cap_ptr;
    s_read_setup(OFS_CAP) |=> PREADY_OUT && PRDATA_OUT == 32'h00000080;
  endproperty
  a_cap_ptr: assert property (p_cap_ptr) else $error("capability pointer not 80h");

  property p_brctl_zero;
    s_read_setup(OFS_BRCTL) |=> PRDATA_OUT[31:23] == 9'h000 && !PRDATA_OUT[21];
  endproperty
  a_brctl_zero: assert property (p_brctl_zero) else $error("hardwired bits not zero");

  property p_pf_limit_wr;
    s_full_write(OFS_PF_LIM_HI) |=> s_q.pf_lim_hi == $past(PWDATA_IN);
  endproperty
  a_pf_limit_wr: assert property (p_pf_limit_wr) else $error("limit high not written");

  property p_pf_limit_rd;
    s_full_write(OFS_PF_LIM_HI) ##2 s_read_setup(OFS_PF_LIM_HI) |=>
      PRDATA_OUT == $past(PWDATA_IN, 3);
  endproperty
  a_pf_limit_rd: assert property (p_pf_limit_rd) else $error("limit high readback wrong");

  property p_hot_reset;
    $rose(s_q.ctl.sec_bus_reset) |=> !PORT_RST_B_OUT[0];
  endproperty
  a_hot_reset: assert property (p_hot_reset) else $error("port reset not asserted");

  property p_err_block;
    ERR_MSG_IN != 3'h0 && !s_q.ctl.secondary_error_forward_enable |=> ERR_FWD_OUT == 3'h0;
  endproperty
  a_err_block: assert property (p_err_block) else $error("error message leaked");

  property p_err_fwd;
    s_q.ctl.secondary_error_forward_enable |=> ERR_FWD_OUT == $past(ERR_MSG_IN);
  endproperty
  a_err_fwd: assert property (p_err_fwd) else $error("error message not forwarded");

  property p_poison;
    POISON_IN |=> POISON_REPORT_OUT == $past(s_q.ctl.parity_resp);
  endproperty
  a_poison: assert property (p_poison) else $error("poison report wrong");

  property p_isa_up;
    IO_REQ_IN && isa_alias |=> IO_FWD_UP_OUT && !IO_FWD_DOWN_OUT;
  endproperty
  a_isa_up: assert property (p_isa_up) else $error("alias I/O not sent upstream");

  property p_vga_mem;
    MEM_REQ_IN && s_q.ctl.vga_en && MEM_ADDR_IN == 64'h00000000000A0000 |=> MEM_FWD_OUT;
  endproperty
  a_vga_mem: assert property (p_vga_mem) else $error("VGA memory not forwarded");

  property p_vga_reserved;
    s_q.ctl.vga_en || s_q.ctl.vga_16bit |-> VGA_OK;
  endproperty
  a_vga_reserved: assert property (p_vga_reserved) else $error("VGA bits set on port two");

  property p_window;
    IO_REQ_IN && !s_q.ctl.legacy_io_alias_mode && !s_q.ctl.vga_en |=>
      IO_FWD_DOWN_OUT == $past(IO_ADDR_IN >= io_base && IO_ADDR_IN <= io_limit);
  endproperty
  a_window: assert property (p_window) else $error("I/O window decode wrong");

  property p_io_hi_wr;
    s_full_write(OFS_IO_HI) |=> {s_q.io_lim_hi, s_q.io_base_hi} == $past(PWDATA_IN);
  endproperty
  a_io_hi_wr: assert property (p_io_hi_wr) else $error("I/O upper bounds not written");

  property p_pf_base_wr;
    s_full_write(OFS_PF_BASE_HI) |=> s_q.pf_base_hi == $past(PWDATA_IN);
  endproperty
  a_pf_base_wr: assert property (p_pf_base_wr) else $error("base high not written");

  property p_pin_ro;
    s_full_write(OFS_BRCTL) ##0 !IRQ_PIN_LOAD_IN |=> $stable(s_q.irq_pin);
  endproperty
  a_pin_ro: assert property (p_pin_ro) else $error("interrupt pin changed by write");

  property p_pin_load;
    IRQ_PIN_LOAD_IN && !IS_UPSTREAM |=> s_q.irq_pin == $past(IRQ_PIN_VALUE_IN);
  endproperty
  a_pin_load: assert property (p_pin_load) else $error("interrupt pin not loaded");

  property p_hot_reset_all;
    s_q.ctl.sec_bus_reset |=> !PORT_RST_B_OUT[0] && PORT_RST_B_OUT[1] == !IS_UPSTREAM;
  endproperty
  a_hot_reset_all: assert property (p_hot_reset_all) else $error("port reset set wrong");

  property p_vga16;
    IO_REQ_IN && s_q.ctl.vga_16bit && IO_ADDR_IN[15:10] != 6'h00 && !io_hit |=>
      !IO_FWD_DOWN_OUT;
  endproperty
  a_vga16: assert property (p_vga16) else $error("16-bit VGA decode too wide");

  property p_isa_low;
    IO_REQ_IN && s_q.ctl.legacy_io_alias_mode && IO_ADDR_IN[9:8] == 2'h0 |=> !IO_FWD_UP_OUT;
  endproperty
  a_isa_low: assert property (p_isa_low) else $error("low quarter sent upstream");

  property p_mem_edges;
    MEM_REQ_IN && !s_q.ctl.vga_en &&
      {s_q.pf_base_hi, s_q.pf_base_lo} <= {s_q.pf_lim_hi, s_q.pf_lim_lo} &&
      (MEM_ADDR_IN[63:20] == {s_q.pf_base_hi, s_q.pf_base_lo} ||
       MEM_ADDR_IN[63:20] == {s_q.pf_lim_hi, s_q.pf_lim_lo}) |=> MEM_FWD_OUT;
  endproperty
  a_mem_edges: assert property (p_mem_edges) else $error("window edge not forwarded");

  property p_status_set;
    ev != '0 |=> (s_q.status & $past(ev)) == $past(ev);
  endproperty
  a_status_set: assert property (p_status_set) else $error("event not recorded");

  property p_refused;
    PSEL_IN && !PENABLE_IN && PADDR_IN[1:0] != 2'h0 |=>
      PSLVERR_OUT && PRDATA_OUT == 32'h00000000;
  endproperty
  a_refused: assert property (p_refused) else $error("misaligned access not refused");
endmodule

// file: hdl/window_compare.sv
// Inclusive address window comparator
`timescale 1ns/1ps
module window_compare #(
  parameter int W = 32
) (
  input wire logic [W-1:0] addr_in,
  input wire logic [W-1:0] base_in,
  input wire logic [W-1:0] limit_in,
  output logic hit_out
);
  assign hit_out = (addr_in >= base_in) && (addr_in <= limit_in);
endmodule
